//--- rtl/core_exc_regs.svh
// What this block does
// - Interrupts stay blocked until the instruction after interrupt enable completes.
// - Stop-clock, flush or management service inside the shadow keeps interrupts blocked.
// - Flag-pop and interrupt-return in legacy mode with privilege below 3 trap, no stack.
// - Stack breakpoint never fires when those instructions trap without touching the stack.
// - Fault address holds page fault address; both control registers survive interrupts.
// - Eight-byte compare uses high and low accumulator against the memory operand.
// - Eight-byte compare accepts only a memory destination; register destination is invalid.
// - Register destination raises invalid opcode, abandons instruction, enters its handler.
// - Locked invalid compare still enters invalid opcode handler, never stalls bus locked.
// - Locked invalid compare checks descriptor entry 6 page; not writeable gives page fault.
// - That page fault is serviced before invalid opcode, so no bus lock arises.
//
// Purpose: constants of the core exception unit
// Assumes: included by rtl files by bare name
// Notes:   definitions only
`ifndef CORE_EXC_REGS_SVH
`define CORE_EXC_REGS_SVH

`define CEX_PRIV_FULL 2'h3
`define CEX_FAULT_ADDR_RST 32'h0000_0000
`define CEX_EXT_CTRL_RST 32'h0000_0000
`define CEX_INVALID_OPCODE_VEC 32'h0000_0006
`define CEX_GATE_BYTES 32'h0000_0008
`define CEX_SYNC_STAGES 3

`endif

//--- rtl/core_exc_pkg.sv
// Purpose: types of the core exception unit
// Assumes: nothing
// Notes:   instruction classes come from the decoder
package core_exc_pkg;

   typedef enum logic [3:0]
   {
      INSTR_OTHER = 4'h0,
      INSTR_SET_IF = 4'h1,
      INSTR_CLEAR_IF = 4'h2,
      INSTR_POP_FLAGS = 4'h3,
      INSTR_INT_RETURN = 4'h4,
      INSTR_CMPX8 = 4'h5,
      INSTR_RESUME_MGMT = 4'h6
   } instr_class_type;

   typedef enum logic [1:0]
   {
      MODE_NORMAL = 2'b01,
      MODE_MGMT = 2'b10
   } mode_type;

endpackage : core_exc_pkg

//--- rtl/pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_in
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Pins
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end
      else
      begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Per bit: accept only where stages two and three agree
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         level_out <= '0;
      else
         level_out <= (stage2 & stage3) | (level_out & (stage2 | stage3));
   end

endmodule : pin_sync
`default_nettype wire

//--- rtl/core_exc_unit.sv
// Purpose: interrupt recognition and exception dispatch at instruction boundaries
// Assumes: exec_in pulses once per instruction with its decode; answers one cycle later
// Notes:   each exec_in marks the boundary after that instruction
`timescale 1ns/1ns
`default_nettype none
`include "core_exc_regs.svh"
module core_exc_unit
   import core_exc_pkg::*;
#(
   parameter int AW = 32
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Instruction from decoder
   input wire logic exec_in,
   input wire logic [3:0] instr_class_in,
   input wire logic dest_is_reg_in,
   input wire logic bus_lock_prefix_in,
   input wire logic legacy_real_emulation_mode_in,
   input wire logic [1:0] io_privilege_level_in,
   // Operands
   input wire logic [31:0] acc_high_reg_in,
   input wire logic [31:0] acc_low_reg_in,
   input wire logic [63:0] mem_value_in,
   // Paging
   input wire logic [AW-1:0] descr_table_base_in,
   input wire logic descr_entry6_writeable_in,
   input wire logic mmu_page_fault_in,
   input wire logic [AW-1:0] mmu_fault_addr_in,
   // Stack breakpoint
   input wire logic stack_bp_armed_in,
   // Control register writes from software
   input wire logic fault_addr_write_in,
   input wire logic ext_ctrl_write_in,
   input wire logic [31:0] ctrl_wdata_in,
   // Pins
   input wire logic ext_irq_in,
   input wire logic stop_clock_request_in,
   input wire logic cache_flush_request_in,
   input wire logic mgmt_interrupt_request_in,
   // Outcome
   output logic done_out,
   output logic general_protection_fault_out,
   output logic invalid_opcode_out,
   output logic page_fault_out,
   output logic stack_access_out,
   output logic data_bp_out,
   output logic bus_lock_out,
   output logic cmp_equal_out,
   // Boundary events
   output logic irq_take_out,
   output logic stop_grant_out,
   output logic flush_service_out,
   output logic mgmt_entry_out,
   output logic mgmt_mode_out,
   output logic shadow_out,
   // Control registers
   output logic [AW-1:0] fault_address_reg_out,
   output logic [31:0] extension_control_reg_out
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [3:0] pins;

   pin_sync #(.WIDTH(4)) u_sync
   (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .pin_in({ext_irq_in, stop_clock_request_in, cache_flush_request_in,
               mgmt_interrupt_request_in}),
      .level_out(pins)
   );

   logic irq_lvl;
   logic stop_lvl;
   logic flush_lvl;
   logic mgmt_lvl;
   assign irq_lvl = pins[3];
   assign stop_lvl = pins[2];
   assign flush_lvl = pins[1];
   assign mgmt_lvl = pins[0];

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function automatic logic [AW-1:0] gate_addr(input logic [AW-1:0] base,
                                              input logic [31:0] vec);
      gate_addr = base + AW'(vec * `CEX_GATE_BYTES);
   endfunction : gate_addr

   instr_class_type cls;
   assign cls = instr_class_type'(instr_class_in);

   logic is_stack_op;
   logic trap_prot;
   logic cmpx_reg;
   logic cmpx_pf;
   logic svc_any;
   mode_type mode;
   logic if_flag;
   assign is_stack_op = (cls == INSTR_POP_FLAGS) || (cls == INSTR_INT_RETURN);
   assign trap_prot = is_stack_op && legacy_real_emulation_mode_in &&
                      (io_privilege_level_in < `CEX_PRIV_FULL);
   assign cmpx_reg = (cls == INSTR_CMPX8) && dest_is_reg_in;
   assign cmpx_pf = cmpx_reg && bus_lock_prefix_in && !descr_entry6_writeable_in;
   assign svc_any = (mode == MODE_NORMAL) && (mgmt_lvl || flush_lvl || stop_lvl);

   // ----------------------------------------
   // Instruction outcome
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         done_out <= 1'b0;
         general_protection_fault_out <= 1'b0;
         invalid_opcode_out <= 1'b0;
         page_fault_out <= 1'b0;
         stack_access_out <= 1'b0;
         data_bp_out <= 1'b0;
         bus_lock_out <= 1'b0;
         cmp_equal_out <= 1'b0;
      end
      else
      begin
         done_out <= exec_in && !trap_prot && !cmpx_reg && !mmu_page_fault_in;
         general_protection_fault_out <= exec_in && trap_prot;
         // Page fault outranks invalid opcode so the lock never forms
         invalid_opcode_out <= exec_in && cmpx_reg && !cmpx_pf;
         page_fault_out <= exec_in && (cmpx_pf || (mmu_page_fault_in && !cmpx_reg));
         stack_access_out <= exec_in && is_stack_op && !trap_prot && !mmu_page_fault_in;
         // Breakpoint follows real stack traffic only, never the trap
         data_bp_out <= exec_in && is_stack_op && !trap_prot && !mmu_page_fault_in &&
                        stack_bp_armed_in;
         // Lock only for a valid memory destination
         bus_lock_out <= exec_in && (cls == INSTR_CMPX8) && !dest_is_reg_in &&
                         bus_lock_prefix_in && !mmu_page_fault_in;
         if (exec_in && (cls == INSTR_CMPX8) && !dest_is_reg_in)
            cmp_equal_out <= ({acc_high_reg_in, acc_low_reg_in} == mem_value_in);
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // Only page faults and software writes touch these; interrupts, breakpoints
   // and management exit leave them alone, so a management handler must restore
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         fault_address_reg_out <= AW'(`CEX_FAULT_ADDR_RST);
      else if (exec_in && cmpx_pf)
         fault_address_reg_out <= gate_addr(descr_table_base_in, `CEX_INVALID_OPCODE_VEC);
      else if (exec_in && mmu_page_fault_in && !cmpx_reg)
         fault_address_reg_out <= mmu_fault_addr_in;
      else if (fault_addr_write_in)
         fault_address_reg_out <= AW'(ctrl_wdata_in);
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         extension_control_reg_out <= `CEX_EXT_CTRL_RST;
      else if (ext_ctrl_write_in)
         extension_control_reg_out <= ctrl_wdata_in;
   end

   // ----------------------------------------
   // Interrupt shadow and flag
   // ----------------------------------------
   logic next_shadow;
   logic take_now;
   // Shadow changes only on executed instructions, never on service events
   assign next_shadow = exec_in ? (cls == INSTR_SET_IF) : shadow_out;
   // Boundary after the interrupt-enable instruction stays closed
   assign take_now = exec_in && if_flag && irq_lvl && !svc_any && (mode == MODE_NORMAL) &&
                     (cls != INSTR_SET_IF) && (cls != INSTR_CLEAR_IF);

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         shadow_out <= 1'b0;
      else
         shadow_out <= next_shadow;
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         if_flag <= 1'b0;
      else if (take_now)
         if_flag <= 1'b0;
      else if (exec_in && (cls == INSTR_SET_IF))
         if_flag <= 1'b1;
      else if (exec_in && (cls == INSTR_CLEAR_IF))
         if_flag <= 1'b0;
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         irq_take_out <= 1'b0;
      else
         irq_take_out <= take_now;
   end

   // ----------------------------------------
   // Boundary services and management mode
   // ----------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         mgmt_entry_out <= 1'b0;
         flush_service_out <= 1'b0;
         stop_grant_out <= 1'b0;
      end
      else
      begin
         mgmt_entry_out <= exec_in && svc_any && mgmt_lvl;
         flush_service_out <= exec_in && svc_any && !mgmt_lvl && flush_lvl;
         stop_grant_out <= exec_in && svc_any && !mgmt_lvl && !flush_lvl;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         mode <= MODE_NORMAL;
      else
      begin
         case (mode)
            MODE_NORMAL:
               if (exec_in && svc_any && mgmt_lvl)
                  mode <= MODE_MGMT;
            MODE_MGMT:
               if (exec_in && (cls == INSTR_RESUME_MGMT))
                  mode <= MODE_NORMAL;
            default:
               mode <= MODE_NORMAL;
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         mgmt_mode_out <= 1'b0;
      else
         mgmt_mode_out <= (mode == MODE_MGMT);
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   chk_set_if_blocks: assert property (
      exec_in && cls == INSTR_SET_IF |=> !irq_take_out ##0 shadow_out)
      else $error("interrupt taken at boundary after interrupt enable");

   chk_svc_shadow: assert property (
      shadow_out && !exec_in |=> shadow_out)
      else $error("shadow lost without an executed instruction");

   chk_prot_trap: assert property (
      exec_in && trap_prot |=> general_protection_fault_out && !stack_access_out && !done_out)
      else $error("flag-pop or return did not trap cleanly");

   chk_trap_no_bp: assert property (
      general_protection_fault_out |-> !data_bp_out ##1 !data_bp_out)
      else $error("stack breakpoint fired on trap");

   chk_cr_hold: assert property (
      !exec_in && !fault_addr_write_in && !ext_ctrl_write_in
      |=> $stable(fault_address_reg_out) && $stable(extension_control_reg_out))
      else $error("control register changed without cause");

   chk_cmp_value: assert property (
      exec_in && cls == INSTR_CMPX8 && !dest_is_reg_in
      |=> cmp_equal_out == ($past({acc_high_reg_in, acc_low_reg_in}) == $past(mem_value_in)))
      else $error("eight-byte compare wrong");

   chk_reg_dest_ud: assert property (
      exec_in && cmpx_reg && !cmpx_pf |=> invalid_opcode_out && !done_out && !bus_lock_out)
      else $error("register destination not rejected");

   chk_ud_no_lock: assert property (
      invalid_opcode_out |-> !bus_lock_out)
      else $error("bus locked on invalid opcode");

   chk_pf_first: assert property (
      exec_in && cmpx_pf |=> page_fault_out && !invalid_opcode_out &&
      fault_address_reg_out == gate_addr($past(descr_table_base_in), `CEX_INVALID_OPCODE_VEC))
      else $error("descriptor page fault not first");

   chk_irq_after: assert property (
      exec_in && shadow_out && if_flag && irq_lvl && !svc_any && mode == MODE_NORMAL &&
      cls != INSTR_SET_IF && cls != INSTR_CLEAR_IF |=> irq_take_out)
      else $error("pending interrupt not taken after shadow");

   cov_shadow_svc: cover property (shadow_out && exec_in && svc_any);
   cov_locked_pf: cover property (exec_in && cmpx_pf);
   cov_trap_bp_armed: cover property (exec_in && trap_prot && stack_bp_armed_in);
   cov_mgmt_round: cover property (mgmt_entry_out ##[1:20] !mgmt_mode_out);

endmodule : core_exc_unit
`default_nettype wire

//--- test/core_exception_interrupt_rules_tb.sv
// Purpose: self-checking bench for the core exception unit
// Assumes: answers one cycle after the exec_in edge; pins settle within five cycles
// Notes:   an idle cycle precedes every instruction so outcome pulses never overlap
`timescale 1ns/1ns
`default_nettype none
module core_exception_interrupt_rules_tb;
   import core_exc_pkg::*;
   // -----------------------------------------------------------
   // Stimulus and observed signals
   // -----------------------------------------------------------
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic exec_in = 1'b0;
   logic [3:0] instr_class_in = 4'h0;
   logic dest_is_reg_in = 1'b0, bus_lock_prefix_in = 1'b0, legacy_real_emulation_mode_in = 1'b0;
   logic [1:0] io_privilege_level_in = 2'h0;
   logic [31:0] acc_high_reg_in = 32'h0, acc_low_reg_in = 32'h0;
   logic [63:0] mem_value_in = 64'h0;
   logic [31:0] descr_table_base_in = 32'h0, mmu_fault_addr_in = 32'h0, ctrl_wdata_in = 32'h0;
   logic descr_entry6_writeable_in = 1'b1, mmu_page_fault_in = 1'b0, stack_bp_armed_in = 1'b0;
   logic fault_addr_write_in = 1'b0, ext_ctrl_write_in = 1'b0, ext_irq_in = 1'b0;
   logic stop_clock_request_in = 1'b0, cache_flush_request_in = 1'b0;
   logic mgmt_interrupt_request_in = 1'b0;
   logic done_out, general_protection_fault_out, invalid_opcode_out, page_fault_out;
   logic stack_access_out;
   logic data_bp_out, bus_lock_out, cmp_equal_out, irq_take_out, stop_grant_out;
   logic flush_service_out, mgmt_entry_out, mgmt_mode_out, shadow_out;
   logic [31:0] fault_address_reg_out, extension_control_reg_out;
   int miscompares = 0;
   int total_checks = 0;

   core_exc_unit i_core_exc_unit (.clk_in, .resetn_in, .exec_in, .instr_class_in,
      .dest_is_reg_in, .bus_lock_prefix_in, .legacy_real_emulation_mode_in,
      .io_privilege_level_in, .acc_high_reg_in, .acc_low_reg_in, .mem_value_in,
      .descr_table_base_in, .descr_entry6_writeable_in, .mmu_page_fault_in,
      .mmu_fault_addr_in, .stack_bp_armed_in,
      .fault_addr_write_in, .ext_ctrl_write_in, .ctrl_wdata_in, .ext_irq_in,
      .stop_clock_request_in, .cache_flush_request_in, .mgmt_interrupt_request_in, .done_out,
      .general_protection_fault_out, .invalid_opcode_out, .page_fault_out, .stack_access_out,
      .data_bp_out,
      .bus_lock_out, .cmp_equal_out, .irq_take_out, .stop_grant_out, .flush_service_out,
      .mgmt_entry_out, .mgmt_mode_out, .shadow_out, .fault_address_reg_out,
      .extension_control_reg_out);

   always #5 clk_in = ~clk_in;

   // -----------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------
   task check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Inputs move 1 ns after the edge
   task tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : tick

   // Idle edge first, then the instruction; its one-cycle outcome stands on return
   task issue(input logic [3:0] cls);
      tick(1);
      instr_class_in = cls;
      exec_in = 1'b1;
      tick(1);
      exec_in = 1'b0;
   endtask : issue

   task sw_write(input logic to_fault, input logic [31:0] d);
      ctrl_wdata_in = d;
      fault_addr_write_in = to_fault;
      ext_ctrl_write_in = ~to_fault;
      tick(1);
      fault_addr_write_in = 1'b0;
      ext_ctrl_write_in = 1'b0;
      tick(1);
   endtask : sw_write

   task print_verdict;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task shadow_check;
      ext_irq_in = 1'b1;
      tick(5);
      issue(INSTR_SET_IF);
      check(irq_take_out, 1'b0);
      check(shadow_out, 1'b1);
      issue(INSTR_OTHER);
      check(irq_take_out, 1'b1);
      check(shadow_out, 1'b0);
      ext_irq_in = 1'b0;
      tick(5);
   endtask : shadow_check

   // Stop-clock, flush and management request in turn, each landing in the shadow
   task service_in_shadow;
      for (int k = 0; k < 3; k++)
      begin
         stop_clock_request_in = (k == 0);
         cache_flush_request_in = (k == 1);
         mgmt_interrupt_request_in = (k == 2);
         ext_irq_in = 1'b1;
         tick(5);
         issue(INSTR_SET_IF);
         check({stop_grant_out, flush_service_out, mgmt_entry_out}, 3'h4 >> k);
         check(irq_take_out, 1'b0);
         check(shadow_out, 1'b1);
         {stop_clock_request_in, cache_flush_request_in, mgmt_interrupt_request_in} = 3'h0;
         tick(5);
         check(mgmt_mode_out, k == 2);
         issue(INSTR_OTHER);
         check(irq_take_out, k != 2);
         if (k == 2)
            issue(INSTR_RESUME_MGMT);
         ext_irq_in = 1'b0;
         tick(5);
      end
   endtask : service_in_shadow

   task prot_trap;
      legacy_real_emulation_mode_in = 1'b1;
      stack_bp_armed_in = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         io_privilege_level_in = i[2:1];
         issue(i[0] ? INSTR_INT_RETURN : INSTR_POP_FLAGS);
         check(general_protection_fault_out, i[2:1] != 2'h3);
         if (i[2:1] != 2'h3)
         begin
            check({stack_access_out, done_out}, 2'h0);
            check(data_bp_out, 1'b0);
         end
         else
            check({stack_access_out, done_out, data_bp_out}, 3'h7);
      end
      legacy_real_emulation_mode_in = 1'b0;
      io_privilege_level_in = 2'h0;
      issue(INSTR_POP_FLAGS);
      check(general_protection_fault_out, 1'b0);
      stack_bp_armed_in = 1'b0;
   endtask : prot_trap

   task fault_regs;
      mmu_page_fault_in = 1'b1;
      mmu_fault_addr_in = 32'h1234_5678;
      issue(INSTR_OTHER);
      mmu_page_fault_in = 1'b0;
      check(page_fault_out, 1'b1);
      check(fault_address_reg_out, 32'h1234_5678);
      sw_write(1'b0, 32'hA5C3_0F18);
      ext_irq_in = 1'b1;
      tick(5);
      issue(INSTR_SET_IF);
      issue(INSTR_OTHER);
      check(irq_take_out, 1'b1);
      check({fault_address_reg_out, extension_control_reg_out}, 64'h1234_5678_A5C3_0F18);
      ext_irq_in = 1'b0;
      mgmt_interrupt_request_in = 1'b1;
      tick(5);
      issue(INSTR_OTHER);
      mgmt_interrupt_request_in = 1'b0;
      tick(5);
      // Handler scribbles on fault address, then restores it before resuming
      sw_write(1'b1, 32'h0BAD_F00D);
      check(fault_address_reg_out, 32'h0BAD_F00D);
      sw_write(1'b1, 32'h1234_5678);
      issue(INSTR_RESUME_MGMT);
      // Mode flag trails the mode by one edge
      tick(1);
      check(mgmt_mode_out, 1'b0);
      check({fault_address_reg_out, extension_control_reg_out}, 64'h1234_5678_A5C3_0F18);
   endtask : fault_regs

   task cmpx8;
      logic [63:0] mems [3];
      mems = '{64'hDEAD_BEEF_0123_4567, 64'hDEAD_BEEF_0123_4566, 64'h5EAD_BEEF_0123_4567};
      acc_high_reg_in = 32'hDEAD_BEEF;
      acc_low_reg_in = 32'h0123_4567;
      for (int i = 0; i < 3; i++)
      begin
         mem_value_in = mems[i];
         bus_lock_prefix_in = (i == 2);
         issue(INSTR_CMPX8);
         check(cmp_equal_out, i == 0);
         check({done_out, invalid_opcode_out}, 2'h2);
         check(bus_lock_out, i == 2);
      end
      {dest_is_reg_in, bus_lock_prefix_in} = 2'h2;
      descr_table_base_in = 32'h0000_3FC8;
      descr_entry6_writeable_in = 1'b0;
      issue(INSTR_CMPX8);
      check({invalid_opcode_out, done_out}, 2'h2);
      check(page_fault_out, 1'b0);
      bus_lock_prefix_in = 1'b1;
      descr_entry6_writeable_in = 1'b1;
      issue(INSTR_CMPX8);
      check(invalid_opcode_out, 1'b1);
      check(bus_lock_out, 1'b0);
      tick(1);
      check(bus_lock_out, 1'b0);
      descr_entry6_writeable_in = 1'b0;
      issue(INSTR_CMPX8);
      check(page_fault_out, 1'b1);
      check(fault_address_reg_out, 32'h0000_3FF8);
      check({invalid_opcode_out, bus_lock_out}, 2'h0);
      {dest_is_reg_in, bus_lock_prefix_in, descr_entry6_writeable_in} = 3'h1;
   endtask : cmpx8

   // -----------------------------------------------------------
   // Main sequence and hang guard
   // -----------------------------------------------------------
   initial
   begin
      tick(12);
      resetn_in = 1'b1;
      tick(1);
      shadow_check();
      service_in_shadow();
      prot_trap();
      fault_regs();
      cmpx8();
      print_verdict();
   end

   initial
   begin
      repeat (20000) @(posedge clk_in);
      miscompares++;
      print_verdict();
   end
endmodule : core_exception_interrupt_rules_tb
`default_nettype wire
